// ===== core/mcsx_defs.vh
// Purpose: constants for the mac control and ip checksum statistics block
// Assumes: byte addressed register port, one word per register
// Notes: included by the counter and top design files; the loop mux does without it
`ifndef MCSX_DEFS_VH
`define MCSX_DEFS_VH

`define MCSX_OFS_MAC_CTRL 8'h6C
`define MCSX_OFS_CSUM_CNT 8'h74
`define MCSX_OFS_INT_STAT 8'h78
`define MCSX_OFS_STAT_MASK 8'h7C
`define MCSX_OFS_TAG_VAL 8'h80

`define MCSX_BIT_GAP_LO 0
`define MCSX_BIT_GAP_HI 1
`define MCSX_BIT_DUPLEX 5
`define MCSX_BIT_BIG_FRAME 6
`define MCSX_BIT_TX_PAUSE 7
`define MCSX_BIT_RX_PAUSE 8
`define MCSX_BIT_KEEP_FCS 9
`define MCSX_BIT_FIFO_WRAP 10
`define MCSX_BIT_MAC_WRAP 11
`define MCSX_BIT_TAG_INS 12
`define MCSX_BIT_TAG_STRIP 13
`define MCSX_BIT_STATS_ON 21
`define MCSX_BIT_STATS_OFF 22
`define MCSX_BIT_STATS_RUN 23
`define MCSX_BIT_STATS_FLAG 7
`define MCSX_BIT_CSUM_SEL 0

`define MCSX_MAC_CTRL_RST 32'h0000_0000
`define MCSX_MAC_CTRL_WMASK 32'h0000_3FE3
`define MCSX_CNT_RST 16'h0000
`define MCSX_CNT_MAX 16'hFFFF
`define MCSX_CNT_NEAR 16'hC000
`define MCSX_OVSZ_STD 13'h05EA
`define MCSX_OVSZ_BIG 13'h118B

`endif

// ===== core/mcsx_csum_cnt.v
// Purpose: sixteen-bit checksum failure counter with near-overflow pulse
// Assumes: event input is a one-cycle pulse per failing frame
// Notes: a host write in the same cycle as an event wins
`timescale 1ns/10ps
`include "mcsx_defs.vh"
module mcsx_csum_cnt #(
    parameter CNT_W = 16
) (
    input wire clk_i,
    input wire resetn_i,
    input wire fail_evt_i,
    input wire count_en_i,
    input wire load_i,
    input wire [CNT_W-1:0] load_val_i,
    output reg [CNT_W-1:0] count_o,
    output reg near_o
);
    wire inc = fail_evt_i & count_en_i;
    wire [CNT_W-1:0] nxt = (count_o == `MCSX_CNT_MAX) ?
        `MCSX_CNT_RST : count_o + 1'b1;

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_o <= `MCSX_CNT_RST;
            near_o <= 1'b0;
        end else begin
            near_o <= 1'b0;
            if (load_i) begin
                count_o <= load_val_i;
            end else if (inc) begin
                count_o <= nxt;
                near_o <= (nxt == `MCSX_CNT_NEAR);
            end
        end
    end
endmodule

// ===== core/mcsx_loop_mux.v
// Purpose: receive path source select for fifo and mac loopback
// Assumes: all sources run on the core clock
// Notes: fifo loopback takes priority when both are set
`timescale 1ns/10ps
module mcsx_loop_mux #(
    parameter DW = 8
) (
    input wire clk_i,
    input wire resetn_i,
    input wire fifo_wrap_i,
    input wire mac_wrap_i,
    input wire [DW-1:0] line_data_i,
    input wire line_dv_i,
    input wire [DW-1:0] txf_data_i,
    input wire txf_dv_i,
    input wire [DW-1:0] mtx_data_i,
    input wire mtx_dv_i,
    output reg [DW-1:0] rx_data_o,
    output reg rx_dv_o
);
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_data_o <= {DW{1'b0}};
            rx_dv_o <= 1'b0;
        end else if (fifo_wrap_i) begin
            rx_data_o <= txf_data_i;
            rx_dv_o <= txf_dv_i;
        end else if (mac_wrap_i) begin
            rx_data_o <= mtx_data_i;
            rx_dv_o <= mtx_dv_i;
        end else begin
            rx_data_o <= line_data_i;
            rx_dv_o <= line_dv_i;
        end
    end
endmodule

// ===== core/mcsx_top.v
// Purpose: mac control bits and ip checksum failure statistics
// Assumes: one core clock; every input is core clock logic
// Notes: register port answers one cycle after a read or write strobe
`timescale 1ns/10ps
`include "mcsx_defs.vh"
module mcsx_top #(
    parameter LVL_W = 16,
    parameter DW = 8
) (
    input wire CORE_CLK_I,
    input wire RESETN_I,
    // register port
    input wire [7:0] REG_ADDR_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    input wire [3:0] REG_BE_I,
    input wire [31:0] REG_WDATA_I,
    output reg [31:0] REG_RDATA_O,
    output reg REG_ACK_O,
    // receive path status
    input wire CSUM_FAIL_I,
    input wire CARRIER_LOSS_EVT_I,
    input wire RX_ACTIVE_I,
    input wire RX_PAUSE_FRAME_I,
    input wire FCS_BAD_I,
    input wire [LVL_W-1:0] RX_FIFO_LEVEL_I,
    input wire [LVL_W-1:0] PAUSE_ON_LEVEL_I,
    input wire [LVL_W-1:0] PAUSE_OFF_LEVEL_I,
    // data sources for the receive path
    input wire [DW-1:0] LINE_RX_DATA_I,
    input wire LINE_RX_DV_I,
    input wire [DW-1:0] TXF_DATA_I,
    input wire TXF_DV_I,
    input wire [DW-1:0] MAC_TX_DATA_I,
    input wire MAC_TX_DV_I,
    // configuration, per-frame controls, flags and receive path data toward the mac
    output reg [1:0] GAP_SELECT_O,
    output reg FULL_DUPLEX_O,
    output reg [12:0] OVERSIZE_LIMIT_O,
    output reg KEEP_FCS_O,
    output reg AUTO_TAG_INSERT_O,
    output reg AUTO_TAG_STRIP_O,
    output reg [15:0] TAG_VALUE_O,
    output reg TX_DEFER_O,
    output reg CARRIER_LOSS_INC_O,
    output reg PAUSE_OBEY_O,
    output reg PAUSE_AS_DATA_O,
    output reg FCS_ERR_O,
    output reg PAUSE_SEND_O,
    output reg PAUSE_RESUME_O,
    output reg STATS_FLAG_O,
    output wire [DW-1:0] RX_PATH_DATA_O,
    output wire RX_PATH_DV_O
);
    // one-hot pause states; any other code falls back to idle
    localparam ST_IDLE = 2'b01;
    localparam ST_HELD = 2'b10;

    reg [31:0] mac_ctrl_q;
    reg [31:0] mac_ctrl_d;
    reg stats_on_q;
    reg stats_mask_q;
    reg stats_flag_q;
    reg [15:0] tag_value_q;
    reg [1:0] pstate_q;
    reg [1:0] pstate_d;
    wire [15:0] csum_count;
    wire csum_near;

    // merge a write into a stored word under the byte enables
    function [31:0] be_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] be;
        integer i;
        begin
            be_merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    be_merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    // one decode used by both the write and the read side
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    wire wr_ctrl = REG_WR_I & hit(REG_ADDR_I, `MCSX_OFS_MAC_CTRL);
    wire wr_cnt = REG_WR_I & hit(REG_ADDR_I, `MCSX_OFS_CSUM_CNT);
    wire wr_mask = REG_WR_I & hit(REG_ADDR_I, `MCSX_OFS_STAT_MASK);
    wire wr_tag = REG_WR_I & hit(REG_ADDR_I, `MCSX_OFS_TAG_VAL);
    wire rd_cnt = REG_RD_I & hit(REG_ADDR_I, `MCSX_OFS_CSUM_CNT);
    wire [31:0] wr_word = be_merge(32'h0000_0000, REG_WDATA_I, REG_BE_I);
    wire [31:0] cnt_word = be_merge({16'h0000, csum_count},
        REG_WDATA_I, REG_BE_I);

    wire duplex = mac_ctrl_q[`MCSX_BIT_DUPLEX];
    wire tx_pause = mac_ctrl_q[`MCSX_BIT_TX_PAUSE];
    wire rx_pause = mac_ctrl_q[`MCSX_BIT_RX_PAUSE];
    wire count_en = stats_on_q & stats_mask_q;
    // tag word merged at full width, only the low half is kept
    wire [31:0] tag_word = be_merge({16'h0000, tag_value_q},
        REG_WDATA_I, REG_BE_I);

    // control bits; reserved bits are never stored so they read zero
    always @* begin
        mac_ctrl_d = mac_ctrl_q;
        if (wr_ctrl) begin
            mac_ctrl_d = (be_merge(mac_ctrl_q, REG_WDATA_I, REG_BE_I)
                & `MCSX_MAC_CTRL_WMASK);
        end
    end

    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mac_ctrl_q <= `MCSX_MAC_CTRL_RST;
            stats_mask_q <= 1'b0;
        end else begin
            mac_ctrl_q <= mac_ctrl_d;
            if (wr_mask) begin
                stats_mask_q <= wr_word[`MCSX_BIT_CSUM_SEL];
            end
        end
    end

    // tag value only feeds the transmit side, no read side effect
    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tag_value_q <= 16'h0000;
        end else if (wr_tag) begin
            tag_value_q <= tag_word[15:0];
        end
    end

    // enable and disable are command strobes; only the state is kept
    // disable beats enable when both arrive in one write
    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            stats_on_q <= 1'b0;
        end else if (wr_ctrl & wr_word[`MCSX_BIT_STATS_OFF]) begin
            stats_on_q <= 1'b0;
        end else if (wr_ctrl & wr_word[`MCSX_BIT_STATS_ON]) begin
            stats_on_q <= 1'b1;
        end
    end

    // a new near-overflow hit in the clearing cycle keeps the flag set
    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            stats_flag_q <= 1'b0;
        end else if (csum_near) begin
            stats_flag_q <= 1'b1;
        end else if (rd_cnt) begin
            stats_flag_q <= 1'b0;
        end
    end

    // a host load beats an event in the same cycle, so a write is exact
    mcsx_csum_cnt #(
        .CNT_W(16)
    ) u_cnt (
        .clk_i(CORE_CLK_I),
        .resetn_i(RESETN_I),
        .fail_evt_i(CSUM_FAIL_I),
        .count_en_i(count_en),
        .load_i(wr_cnt),
        .load_val_i(cnt_word[15:0]),
        .count_o(csum_count),
        .near_o(csum_near)
    );

    // register read port; data stands only in the ack cycle
    // reads have no side effect except the counter clearing the flag
    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            REG_RDATA_O <= 32'h0000_0000;
            REG_ACK_O <= 1'b0;
        end else begin
            REG_ACK_O <= REG_RD_I | REG_WR_I;
            if (!REG_RD_I) begin
                REG_RDATA_O <= 32'h0000_0000;
            end else if (hit(REG_ADDR_I, `MCSX_OFS_MAC_CTRL)) begin
                REG_RDATA_O <= mac_ctrl_q |
                    ({31'h0000_0000, stats_on_q} << `MCSX_BIT_STATS_RUN);
            end else if (hit(REG_ADDR_I, `MCSX_OFS_CSUM_CNT)) begin
                REG_RDATA_O <= {16'h0000, csum_count};
            end else if (hit(REG_ADDR_I, `MCSX_OFS_INT_STAT)) begin
                REG_RDATA_O <= {31'h0000_0000, stats_flag_q}
                    << `MCSX_BIT_STATS_FLAG;
            end else if (hit(REG_ADDR_I, `MCSX_OFS_STAT_MASK)) begin
                REG_RDATA_O <= {31'h0000_0000, stats_mask_q}
                    << `MCSX_BIT_CSUM_SEL;
            end else if (hit(REG_ADDR_I, `MCSX_OFS_TAG_VAL)) begin
                REG_RDATA_O <= {16'h0000, tag_value_q};
            end else begin
                REG_RDATA_O <= 32'h0000_0000;
            end
        end
    end

    // configuration outputs, registered so they change one edge late
    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            GAP_SELECT_O <= 2'h0;
            FULL_DUPLEX_O <= 1'b0;
            OVERSIZE_LIMIT_O <= `MCSX_OVSZ_STD;
            KEEP_FCS_O <= 1'b0;
            AUTO_TAG_INSERT_O <= 1'b0;
            AUTO_TAG_STRIP_O <= 1'b0;
            TAG_VALUE_O <= 16'h0000;
            STATS_FLAG_O <= 1'b0;
        end else begin
            GAP_SELECT_O <=
                mac_ctrl_q[`MCSX_BIT_GAP_HI:`MCSX_BIT_GAP_LO];
            FULL_DUPLEX_O <= duplex;
            OVERSIZE_LIMIT_O <= mac_ctrl_q[`MCSX_BIT_BIG_FRAME] ?
                `MCSX_OVSZ_BIG : `MCSX_OVSZ_STD;
            KEEP_FCS_O <= mac_ctrl_q[`MCSX_BIT_KEEP_FCS];
            AUTO_TAG_INSERT_O <= mac_ctrl_q[`MCSX_BIT_TAG_INS];
            AUTO_TAG_STRIP_O <= mac_ctrl_q[`MCSX_BIT_TAG_STRIP];
            TAG_VALUE_O <= tag_value_q;
            STATS_FLAG_O <= stats_flag_q;
        end
    end

    // per-frame gating of duplex and flow-control behaviour
    // full duplex never defers, so the mac needs no duplex logic of its own
    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            TX_DEFER_O <= 1'b0;
            CARRIER_LOSS_INC_O <= 1'b0;
            PAUSE_OBEY_O <= 1'b0;
            PAUSE_AS_DATA_O <= 1'b0;
            FCS_ERR_O <= 1'b0;
        end else begin
            TX_DEFER_O <= RX_ACTIVE_I & ~duplex;
            CARRIER_LOSS_INC_O <= CARRIER_LOSS_EVT_I & ~duplex
                & stats_on_q;
            PAUSE_OBEY_O <= RX_PAUSE_FRAME_I & rx_pause;
            PAUSE_AS_DATA_O <= RX_PAUSE_FRAME_I & ~rx_pause;
            FCS_ERR_O <= FCS_BAD_I;
        end
    end

    // pause generator with hysteresis between the two levels
    // equal levels are allowed: on at or above, off at or below
    always @* begin
        pstate_d = pstate_q;
        case (pstate_q)
            ST_IDLE: begin
                if (tx_pause && RX_FIFO_LEVEL_I >= PAUSE_ON_LEVEL_I) begin
                    pstate_d = ST_HELD;
                end
            end
            ST_HELD: begin
                if (!tx_pause || RX_FIFO_LEVEL_I <= PAUSE_OFF_LEVEL_I) begin
                    pstate_d = ST_IDLE;
                end
            end
            default: begin
                pstate_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            pstate_q <= ST_IDLE;
            PAUSE_SEND_O <= 1'b0;
            PAUSE_RESUME_O <= 1'b0;
        end else begin
            pstate_q <= pstate_d;
            PAUSE_SEND_O <= pstate_q[0] & pstate_d[1];
            PAUSE_RESUME_O <= pstate_q[1] & pstate_d[0];
        end
    end

    // loopback switches mid-frame; the host resets both paths after
    mcsx_loop_mux #(
        .DW(DW)
    ) u_loop (
        .clk_i(CORE_CLK_I),
        .resetn_i(RESETN_I),
        .fifo_wrap_i(mac_ctrl_q[`MCSX_BIT_FIFO_WRAP]),
        .mac_wrap_i(mac_ctrl_q[`MCSX_BIT_MAC_WRAP]),
        .line_data_i(LINE_RX_DATA_I),
        .line_dv_i(LINE_RX_DV_I),
        .txf_data_i(TXF_DATA_I),
        .txf_dv_i(TXF_DV_I),
        .mtx_data_i(MAC_TX_DATA_I),
        .mtx_dv_i(MAC_TX_DV_I),
        .rx_data_o(RX_PATH_DATA_O),
        .rx_dv_o(RX_PATH_DV_O)
    );
endmodule

// ===== dv/mcsx_props.sv
// Purpose: port level checks of the mac control and statistics block
// Assumes: one core clock, asynchronous active low reset
// Notes: bound to every mcsx_top instance
`timescale 1ns/10ps
module mcsx_props #(
    parameter LVL_W = 16,
    parameter DW = 8
) (
    input logic CORE_CLK_I,
    input logic RESETN_I,
    input logic REG_WR_I,
    input logic REG_RD_I,
    input logic REG_ACK_O,
    input logic CARRIER_LOSS_EVT_I,
    input logic RX_ACTIVE_I,
    input logic RX_PAUSE_FRAME_I,
    input logic FCS_BAD_I,
    input logic LINE_RX_DV_I,
    input logic TXF_DV_I,
    input logic MAC_TX_DV_I,
    input logic FULL_DUPLEX_O,
    input logic [12:0] OVERSIZE_LIMIT_O,
    input logic TX_DEFER_O,
    input logic CARRIER_LOSS_INC_O,
    input logic PAUSE_OBEY_O,
    input logic PAUSE_AS_DATA_O,
    input logic FCS_ERR_O,
    input logic PAUSE_SEND_O,
    input logic PAUSE_RESUME_O,
    input logic STATS_FLAG_O,
    input logic RX_PATH_DV_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);
    logic dup_q1, dup_q2;
    logic [2:0] rd_age_q;
    // duplex output lags the register, so judge only once it has settled
    wire dup_held = (FULL_DUPLEX_O == dup_q1) && (dup_q1 == dup_q2);
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            dup_q1 <= 1'b0;
            dup_q2 <= 1'b0;
            rd_age_q <= 3'd7;
        end else begin
            dup_q1 <= FULL_DUPLEX_O;
            dup_q2 <= dup_q1;
            if (REG_RD_I) begin
                rd_age_q <= 3'd0;
            end else if (rd_age_q != 3'd7) begin
                rd_age_q <= rd_age_q + 3'd1;
            end
        end
    end
    ack_after_strobe_a: assert property (
        (REG_WR_I || REG_RD_I) |=> REG_ACK_O)
        else $error("no ack after a register strobe");
    defer_half_a: assert property (dup_held |->
        TX_DEFER_O == ($past(RX_ACTIVE_I) && !FULL_DUPLEX_O))
        else $error("deferral does not follow receive activity");
    carrier_gate_a: assert property (CARRIER_LOSS_INC_O |->
        $past(CARRIER_LOSS_EVT_I) && !(dup_held && FULL_DUPLEX_O))
        else $error("carrier loss counted wrongly");
    pause_split_a: assert property (
        !(PAUSE_OBEY_O && PAUSE_AS_DATA_O) &&
        ((PAUSE_OBEY_O || PAUSE_AS_DATA_O) == $past(RX_PAUSE_FRAME_I)))
        else $error("pause frame handling wrong");
    fcs_delay_a: assert property (FCS_ERR_O == $past(FCS_BAD_I))
        else $error("fcs error report wrong");
    oversize_set_a: assert property (OVERSIZE_LIMIT_O == 13'h05EA ||
        OVERSIZE_LIMIT_O == 13'h118B)
        else $error("oversize limit not a legal value");
    pause_pulse_a: assert property (
        PAUSE_SEND_O |-> !PAUSE_RESUME_O ##1 !PAUSE_SEND_O)
        else $error("pause send not a lone pulse");
    rx_source_a: assert property (RX_PATH_DV_O |->
        $past(LINE_RX_DV_I || TXF_DV_I || MAC_TX_DV_I))
        else $error("receive path valid without a source");
    flag_clear_a: assert property (
        $fell(STATS_FLAG_O) |-> rd_age_q < 3'd5)
        else $error("statistics flag fell without a read");
    cover property ($rose(STATS_FLAG_O));
    cover property (PAUSE_SEND_O);
    cover property (PAUSE_RESUME_O);
    cover property (RX_PATH_DV_O && FULL_DUPLEX_O);
endmodule
bind mcsx_top mcsx_props #(.LVL_W(LVL_W), .DW(DW)) u_props (
    .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I), .REG_ACK_O(REG_ACK_O),
    .CARRIER_LOSS_EVT_I(CARRIER_LOSS_EVT_I), .RX_ACTIVE_I(RX_ACTIVE_I),
    .RX_PAUSE_FRAME_I(RX_PAUSE_FRAME_I), .FCS_BAD_I(FCS_BAD_I),
    .LINE_RX_DV_I(LINE_RX_DV_I), .TXF_DV_I(TXF_DV_I),
    .MAC_TX_DV_I(MAC_TX_DV_I), .FULL_DUPLEX_O(FULL_DUPLEX_O),
    .OVERSIZE_LIMIT_O(OVERSIZE_LIMIT_O), .TX_DEFER_O(TX_DEFER_O),
    .CARRIER_LOSS_INC_O(CARRIER_LOSS_INC_O), .PAUSE_OBEY_O(PAUSE_OBEY_O),
    .PAUSE_AS_DATA_O(PAUSE_AS_DATA_O), .FCS_ERR_O(FCS_ERR_O),
    .PAUSE_SEND_O(PAUSE_SEND_O), .PAUSE_RESUME_O(PAUSE_RESUME_O),
    .STATS_FLAG_O(STATS_FLAG_O), .RX_PATH_DV_O(RX_PATH_DV_O));

// ===== dv/mcsx_top_tb.sv
// Purpose: self-checking bench of the mac control and statistics block
// Assumes: inputs change at the falling clock edge
// Notes: side inputs run random once reset is released; registers via tasks
`timescale 1ns/10ps
`include "mcsx_defs.vh"
module mcsx_top_tb;
    logic clk, rstn, wr, rd, ack, fail, cev, ract, rpf, fbad;
    logic ldv, tdv, mdv, rdv, dup, keep, ins, strip, dfr, cinc, obey;
    logic pdat, ferr, psend, pres, flag, st, held, send_e, res_e;
    logic [7:0] addr, ld, td, md, rxd;
    logic [3:0] be, bev;
    logic [31:0] wdat, rdat, rd_v, mc, wd, rnd, mcl;
    logic [15:0] lvl, tagv, pon, poff;
    logic [12:0] ovsz;
    logic [1:0] gap;
    integer seed, miscompares, checked, i;
    mcsx_top uut (.CORE_CLK_I(clk), .RESETN_I(rstn), .REG_ADDR_I(addr),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_BE_I(be), .REG_WDATA_I(wdat),
        .REG_RDATA_O(rdat), .REG_ACK_O(ack), .CSUM_FAIL_I(fail),
        .CARRIER_LOSS_EVT_I(cev), .RX_ACTIVE_I(ract), .RX_PAUSE_FRAME_I(rpf),
        .FCS_BAD_I(fbad), .RX_FIFO_LEVEL_I(lvl),
        .PAUSE_ON_LEVEL_I(pon), .PAUSE_OFF_LEVEL_I(poff),
        .LINE_RX_DATA_I(ld), .LINE_RX_DV_I(ldv), .TXF_DATA_I(td),
        .TXF_DV_I(tdv), .MAC_TX_DATA_I(md), .MAC_TX_DV_I(mdv),
        .GAP_SELECT_O(gap), .FULL_DUPLEX_O(dup), .OVERSIZE_LIMIT_O(ovsz),
        .KEEP_FCS_O(keep), .AUTO_TAG_INSERT_O(ins), .AUTO_TAG_STRIP_O(strip),
        .TAG_VALUE_O(tagv), .TX_DEFER_O(dfr), .CARRIER_LOSS_INC_O(cinc),
        .PAUSE_OBEY_O(obey), .PAUSE_AS_DATA_O(pdat), .FCS_ERR_O(ferr),
        .PAUSE_SEND_O(psend), .PAUSE_RESUME_O(pres), .STATS_FLAG_O(flag),
        .RX_PATH_DATA_O(rxd), .RX_PATH_DV_O(rdv));
    task automatic complete_run;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
        checked = checked + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic acc(input logic w, logic [7:0] a, logic [3:0] b,
        logic [31:0] d);
        @(negedge clk);
        wr = w;
        rd = !w;
        addr = a;
        be = b;
        wdat = d;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        chk("ack", 32'h0000_0001, {31'h0, ack});
        rd_v = rdat;
        if (w && a == `MCSX_OFS_MAC_CTRL) mcl = mc;
    endtask
    task automatic pulse_fail(input integer n);
        repeat (n) begin
            @(negedge clk);
            fail = 1'b1;
        end
        @(negedge clk);
        fail = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // side inputs sampled last posedge still stand here, outputs show them
    task automatic chk_side;
        @(negedge clk);
        chk("defer", {31'h0, ract & !mc[5]}, {31'h0, dfr});
        chk("carrier", {31'h0, cev & !mc[5] & st}, {31'h0, cinc});
        chk("obey", {31'h0, rpf & mc[8]}, {31'h0, obey});
        chk("as_data", {31'h0, rpf & !mc[8]}, {31'h0, pdat});
        chk("fcs_err", {31'h0, fbad}, {31'h0, ferr});
        chk("rx_path", {23'h0, mc[10] ? {tdv, td} : mc[11] ? {mdv, md} :
            {ldv, ld}}, {23'h0, rdv, rxd});
        chk("gap", {30'h0, mc[1:0]}, {30'h0, gap});
        chk("duplex", {31'h0, mc[5]}, {31'h0, dup});
        chk("ovsz", mc[6] ? 32'h0000_118B : 32'h0000_05EA,
            {19'h0, ovsz});
        chk("keep", {31'h0, mc[9]}, {31'h0, keep});
        chk("ins", {31'h0, mc[12]}, {31'h0, ins});
        chk("strip", {31'h0, mc[13]}, {31'h0, strip});
        chk("pause_send", {31'h0, send_e}, {31'h0, psend});
        chk("pause_resume", {31'h0, res_e}, {31'h0, pres});
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    initial begin
        #20000;
        miscompares = miscompares + 1;
        complete_run();
    end
    always @(negedge clk) begin
        rnd = $random(seed);
        if (rstn) begin
            {md, td, ld} <= rnd[31:8];
            {mdv, tdv, ldv, fbad, rpf, cev, ract} <= rnd[6:0];
            lvl <= {8'h00, rnd[31:24]};
        end
    end
    // bench copy of the pause hysteresis, fed by the control word it wrote
    always @(posedge clk) begin
        if (rstn) begin
            held <= mcl[7] && (held ? lvl > poff : lvl >= pon);
            send_e <= !held && mcl[7] && lvl >= pon;
            res_e <= held && !(mcl[7] && lvl > poff);
        end
    end
    initial begin
        seed = 11798;
        {miscompares, checked, mc, st, rstn, wr, rd, fail} = '0;
        {addr, be, wdat, cev, ract, rpf, fbad, lvl} = '0;
        {ld, ldv, td, tdv, md, mdv, held, send_e, res_e, mcl} = '0;
        pon = {8'h00, 1'b1, 7'($random(seed))};
        poff = {9'h000, 7'($random(seed))};
        repeat (3) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        chk("ovsz_rst", 32'h0000_05EA, {19'h0, ovsz});
        acc(1'b0, `MCSX_OFS_MAC_CTRL, 4'hF, 32'h0);
        chk("mac_rst", `MCSX_MAC_CTRL_RST, rd_v);
        acc(1'b0, `MCSX_OFS_CSUM_CNT, 4'hF, 32'h0);
        chk("cnt_rst", 32'h0000_0000, rd_v);
        for (i = 0; i < 14; i = i + 1) begin
            wd = $random(seed);
            bev = (i < 3) ? 4'hF : 4'($random(seed));
            bev[1] = bev[0];
            wd[22:21] = 2'b00;
            wd[8:7] = wd[8:7] & {2{wd[5]}};
            if (i >= 3) wd[9] = mc[9];
            // path resets and tx frame spacing lie outside the block
            if (i == 6) begin
                wd[21] = 1'b1;
                bev[2] = 1'b1;
                st = 1'b1;
            end
            mc = (mc & ~{{8{bev[3]}}, {8{bev[2]}}, {8{bev[1]}}, {8{bev[0]}}})
                | (wd & {{8{bev[3]}}, {8{bev[2]}}, {8{bev[1]}}, {8{bev[0]}}});
            acc(1'b1, `MCSX_OFS_MAC_CTRL, bev, wd);
            acc(1'b0, `MCSX_OFS_MAC_CTRL, 4'hF, 32'h0);
            chk("mac_ctrl", (mc & `MCSX_MAC_CTRL_WMASK) | {8'h0, st, 23'h0},
                rd_v);
            repeat (2) chk_side();
        end
        acc(1'b1, 8'h90, 4'hF, 32'hFFFF_FFFF);
        acc(1'b0, 8'h90, 4'hF, 32'h0);
        chk("unmapped", 32'h0000_0000, rd_v);
        wd = $random(seed);
        acc(1'b1, `MCSX_OFS_TAG_VAL, 4'hF, wd);
        acc(1'b0, `MCSX_OFS_TAG_VAL, 4'hF, 32'h0);
        chk("tag_rd", {16'h0, wd[15:0]}, rd_v);
        chk("tag_out", {16'h0, wd[15:0]}, {16'h0, tagv});
        acc(1'b1, `MCSX_OFS_STAT_MASK, 4'hF, 32'h0000_0001);
        acc(1'b1, `MCSX_OFS_CSUM_CNT, 4'hF, 32'h0000_BFFE);
        pulse_fail(2);
        acc(1'b0, `MCSX_OFS_INT_STAT, 4'hF, 32'h0);
        chk("stat_bit", 32'h0000_0080, rd_v & 32'h0000_0080);
        chk("flag_out", 32'h0000_0001, {31'h0, flag});
        acc(1'b0, `MCSX_OFS_CSUM_CNT, 4'hF, 32'h0);
        chk("cnt_near", 32'h0000_C000, rd_v);
        repeat (3) @(negedge clk);
        acc(1'b0, `MCSX_OFS_INT_STAT, 4'hF, 32'h0);
        chk("stat_clr", 32'h0000_0000, rd_v & 32'h0000_0080);
        acc(1'b1, `MCSX_OFS_STAT_MASK, 4'hF, 32'h0);
        pulse_fail(3);
        acc(1'b1, `MCSX_OFS_STAT_MASK, 4'hF, 32'h0000_0001);
        acc(1'b1, `MCSX_OFS_MAC_CTRL, 4'hF,
            (mc & `MCSX_MAC_CTRL_WMASK) | 32'h0060_0000);
        pulse_fail(2);
        acc(1'b0, `MCSX_OFS_CSUM_CNT, 4'hF, 32'h0);
        chk("cnt_gated", 32'h0000_C000, rd_v);
        acc(1'b1, `MCSX_OFS_MAC_CTRL, 4'hF,
            (mc & `MCSX_MAC_CTRL_WMASK) | 32'h0020_0000);
        acc(1'b1, `MCSX_OFS_CSUM_CNT, 4'hF, 32'h0000_FFFE);
        pulse_fail(2);
        acc(1'b0, `MCSX_OFS_CSUM_CNT, 4'hF, 32'h0);
        chk("cnt_wrap", 32'h0000_0000, rd_v);
        complete_run();
    end
endmodule
